// *** cal_channel_assess.sv ***
`timescale 1ns/1ns
// Functional notes
// - complete flag 0 while measuring, 1 after
// - result stored at completion, cleared on request
// - result bit: 0 busy, 1 idle
// - trigger bit 7 starts measurement, self-clears
// - mode field 6:5 selects combination, resets 1
// - energy busy above floor plus 2.07 dB steps
// - fixed 5 ms listen, clear means send
// - busy means random 5-10 ms relisten, repeat
// - acknowledgements skip listening
// - listening only in extended operating mode
// - select bit 6 zero keeps backoff algorithm
// - listening ignores retry and exponent limits
// - forced state commands cancel listening
// - listening shares mode and threshold fields
// - manual trigger plays no listening role
// - manual measurement ends 8 symbols plus 12 us
// - request clears complete flag until finished
// - request outside basic receive completes immediately
module cal_channel_assess
  import cal_pkg::*;
#(
  parameter int                 ASSESS_CYCLES = ASSESS_CYC,
  parameter int                 STEP_CYCLES   = LISTEN_STEP_CYC,
  parameter logic signed [15:0] SIGNAL_FLOOR  = -16'sd10000
)
(
  // clock and reset
  input  wire logic               sys_clk_in,
  input  wire logic               rst_in,
  // register port
  input  wire logic [5:0]         reg_addr_in,
  input  wire logic [7:0]         reg_wdata_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  output logic      [7:0]         reg_rdata_out,
  // radio state from the transceiver core
  input  wire logic [4:0]         radio_state_in,
  input  wire logic               basic_rx_state_in,
  input  wire logic               extended_mode_in,
  input  wire logic               state_cmd_wr_in,
  input  wire logic [4:0]         state_command_in,
  // channel detectors
  input  wire logic               carrier_sense_in,
  input  wire logic signed [15:0] rx_power_in,
  // auto-retry transmit sequencer
  input  wire logic               aret_access_req_in,
  input  wire logic               aret_ack_frame_in,
  output logic                    aret_use_listen_out,
  output logic                    tx_go_out,
  output logic                    listen_active_out,
  // status outputs
  output logic                    assess_done_event_out,
  output logic      [4:0]         channel_out
);

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_MANUAL = 2'b01,
    ST_LISTEN = 2'b10
  } cal_state_t;

  cal_state_t  state;          // controller state
  logic [31:0] assess_cnt;     // cycles into a manual measurement
  logic        busy_seen;      // busy observed during current window
  logic        complete_flag;  // assessment finished
  logic        idle_flag;      // last result, 1 = idle
  logic [1:0]  mode;           // assessment mode field
  logic [7:0]  thres_reg;      // threshold register, reserved bits kept
  logic [7:0]  ext_ctrl;       // extended operation control

  cal_listen_if lt ();         // link to the listening timer

  // energy detector: power in hundredths of a dBm
  function automatic logic energy_busy(input logic signed [15:0] pwr, input logic [3:0] step);
    logic signed [16:0] lvl;
    lvl = 17'(SIGNAL_FLOOR) + THRES_STEP_CDB * $signed({1'b0, step});
    energy_busy = 17'(pwr) > lvl;
  endfunction

  // combine detectors as the mode field asks
  function automatic logic chan_busy(input logic [1:0] m, input logic cs, input logic ed);
    case (cal_mode_t'(m))
      CAL_MODE_CS_OR_ED:  chan_busy = cs | ed;
      CAL_MODE_ED_ONLY:   chan_busy = ed;
      CAL_MODE_CS_ONLY:   chan_busy = cs;
      default:            chan_busy = cs & ed;
    endcase
  endfunction

  // register write decode
  wire wr_ctrl   = reg_wr_in && (reg_addr_in == ASSESS_CTRL_ADDR);
  wire wr_thres  = reg_wr_in && (reg_addr_in == ENERGY_THRES_ADDR);
  wire wr_ext    = reg_wr_in && (reg_addr_in == EXT_OP_CTRL_ADDR);
  wire trigger   = wr_ctrl && reg_wdata_in[TRIGGER_BIT];
  wire manual_go = trigger && (state != ST_LISTEN);
  wire manual_skip = manual_go && !(basic_rx_state_in && !extended_mode_in);

  // one busy decision shared by both users
  wire ed_busy   = energy_busy(rx_power_in, thres_reg[3:0]);
  wire busy_now  = chan_busy(mode, carrier_sense_in, ed_busy);

  wire listen_sel = extended_mode_in && ext_ctrl[LISTEN_SEL_BIT];
  wire force_cmd  = state_cmd_wr_in &&
                    (state_command_in == CMD_FORCED_SYNTH_ON || state_command_in == CMD_FORCED_RADIO_OFF);
  wire ack_go     = aret_access_req_in && listen_sel && aret_ack_frame_in && (state == ST_IDLE);
  wire listen_go  = aret_access_req_in && listen_sel && !aret_ack_frame_in && (state == ST_IDLE);
  wire manual_end = (state == ST_MANUAL) && (assess_cnt == 32'(ASSESS_CYCLES - 1));
  wire period_busy = busy_seen | busy_now;
  wire listen_abort = (state == ST_LISTEN) && force_cmd;

  // read mux, reserved bits read zero where marked read-only
  wire [7:0] rd_mux =
    (reg_addr_in == RADIO_STATUS_ADDR) ? {complete_flag, idle_flag, 1'b0, radio_state_in} :
    (reg_addr_in == ASSESS_CTRL_ADDR)  ? {1'b0, mode, channel_out} :
    (reg_addr_in == ENERGY_THRES_ADDR) ? thres_reg :
    (reg_addr_in == EXT_OP_CTRL_ADDR)  ? ext_ctrl : 8'h00;

  // timer controls: a busy period chains straight into a random one
  // random relisten after busy
  // no retry limit, loops until clear or cancel
  assign lt.start      = listen_go || (state == ST_LISTEN && lt.done && period_busy && !force_cmd);
  assign lt.random_len = (state == ST_LISTEN);
  assign lt.abort      = listen_abort;
  assign aret_use_listen_out = listen_sel;

  // period lengths from the pseudo-random timer
  cal_listen_timer #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_timer (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .lt         (lt)
  );

  // read data register
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
      reg_rdata_out <= rd_mux;
  end

  // configuration registers
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      mode        <= MODE_RESET;
      channel_out <= CHANNEL_RESET;
      thres_reg   <= THRES_RESET;
      ext_ctrl    <= EXT_CTRL_RESET;
    end
    else
    begin
      if (wr_ctrl)
      begin
        mode        <= reg_wdata_in[MODE_LSB +: 2];
        channel_out <= reg_wdata_in[4:0];
      end
      if (wr_thres)
        thres_reg <= reg_wdata_in;
      // bit 0 is read-only zero
      if (wr_ext)
        ext_ctrl <= reg_wdata_in & EXT_CTRL_WR_MASK;
    end
  end

  // controller state machine
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      state      <= ST_IDLE;
      assess_cnt <= 32'h0;
      busy_seen  <= 1'b0;
      tx_go_out  <= 1'b0;
    end
    else
    begin
      tx_go_out <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          busy_seen  <= 1'b0;
          assess_cnt <= 32'h0;
          if (ack_go)
            tx_go_out <= 1'b1;
          else if (listen_go)
            state <= ST_LISTEN;
          else if (manual_go && !manual_skip)
            state <= ST_MANUAL;
        end
        ST_MANUAL:
        begin
          // a fresh trigger restarts the window
          // fixed measurement length
          if (trigger)
          begin
            assess_cnt <= 32'h0;
            busy_seen  <= 1'b0;
            if (manual_skip)
              state <= ST_IDLE;
          end
          else if (manual_end)
            state <= ST_IDLE;
          else
          begin
            assess_cnt <= assess_cnt + 32'h1;
            busy_seen  <= period_busy;
          end
        end
        ST_LISTEN:
        begin
          if (listen_abort)
            state <= ST_IDLE;
          else if (lt.done)
          begin
            busy_seen <= 1'b0;
            if (!period_busy)
            begin
              tx_go_out <= 1'b1;
              state     <= ST_IDLE;
            end
          end
          else
            busy_seen <= period_busy;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // completion flag, result and done pulse
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      complete_flag         <= 1'b0;
      idle_flag             <= 1'b0;
      assess_done_event_out <= 1'b0;
    end
    else
    begin
      assess_done_event_out <= 1'b0;
      if (manual_go)
      begin
        complete_flag <= 1'b0;
        idle_flag     <= 1'b0;
      end
      // completion written last so it wins over a same-cycle clear
      if (manual_skip)
      begin
        complete_flag         <= 1'b1;
        assess_done_event_out <= 1'b1;
      end
      else if (manual_end && !trigger)
      begin
        complete_flag         <= 1'b1;
        idle_flag             <= !period_busy;
        assess_done_event_out <= 1'b1;
      end
    end
  end

  assign listen_active_out = (state == ST_LISTEN);

  // helper: length of the current listening period
  logic [31:0] per_cnt;
  logic        first_per;
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in || lt.start)
      per_cnt <= 32'h1;
    else
      per_cnt <= per_cnt + 32'h1;
  end
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      first_per <= 1'b0;
    else if (lt.start)
      first_per <= !lt.random_len;
  end

  a_request_clears_done: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    manual_go && basic_rx_state_in && !extended_mode_in |=> !complete_flag)
    else $error("complete flag not cleared by request");

  a_request_clears_idle: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    manual_go |=> !idle_flag || complete_flag)
    else $error("result not cleared by request");

  a_manual_length: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    assess_done_event_out && $past(state) == ST_MANUAL && !$past(manual_skip)
      |-> $past(assess_cnt) == 32'(ASSESS_CYCLES - 1))
    else $error("manual measurement length wrong");

  a_outside_rx: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    manual_go && !basic_rx_state_in |=> assess_done_event_out && complete_flag && !idle_flag)
    else $error("request outside receive not completed at once");

  a_trigger_reads0: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    reg_rd_in && reg_addr_in == ASSESS_CTRL_ADDR |=> !reg_rdata_out[TRIGGER_BIT])
    else $error("trigger bit reads back set");

  a_ack_skip: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ack_go |=> tx_go_out && !listen_active_out)
    else $error("acknowledgement was made to listen");

  a_cancel_listen: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    listen_active_out && force_cmd |=> !listen_active_out && !lt.running && !tx_go_out)
    else $error("forced command did not cancel listening");

  a_fixed_period: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    lt.done && first_per |-> per_cnt == 32'(LISTEN_FIXED_UNITS * STEP_CYCLES))
    else $error("first listening period not fixed length");

  a_random_period: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    lt.done && !first_per |-> per_cnt >= 32'(LISTEN_FIXED_UNITS * STEP_CYCLES)
                           && per_cnt <= 32'(LISTEN_MAX_UNITS * STEP_CYCLES))
    else $error("random listening period out of range");

  a_csma_default: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !ext_ctrl[LISTEN_SEL_BIT] || !extended_mode_in |-> !aret_use_listen_out)
    else $error("listening selected without select bit");

  a_trigger_no_listen: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    listen_active_out && trigger && !force_cmd && !lt.done |=> listen_active_out && !assess_done_event_out)
    else $error("manual trigger disturbed listening");

endmodule

// *** cal_pkg.sv ***
package cal_pkg;

  // register indices on the documented register port
  localparam logic [5:0] RADIO_STATUS_ADDR   = 6'h01;
  localparam logic [5:0] ASSESS_CTRL_ADDR    = 6'h08;
  localparam logic [5:0] ENERGY_THRES_ADDR   = 6'h09;
  localparam logic [5:0] EXT_OP_CTRL_ADDR    = 6'h17;

  // field positions
  localparam int COMPLETE_BIT   = 7;
  localparam int IDLE_BIT       = 6;
  localparam int TRIGGER_BIT    = 7;
  localparam int MODE_LSB       = 5;
  localparam int LISTEN_SEL_BIT = 6;

  // values after reset
  localparam logic [1:0] MODE_RESET        = 2'h1;
  localparam logic [4:0] CHANNEL_RESET     = 5'h00;
  localparam logic [7:0] THRES_RESET       = 8'h77;
  localparam logic [7:0] EXT_CTRL_RESET    = 8'h00;
  localparam logic [7:0] EXT_CTRL_WR_MASK  = 8'hfe;

  // assessment modes
  typedef enum logic [1:0] {
    CAL_MODE_CS_OR_ED  = 2'b00,
    CAL_MODE_ED_ONLY   = 2'b01,
    CAL_MODE_CS_ONLY   = 2'b10,
    CAL_MODE_CS_AND_ED = 2'b11
  } cal_mode_t;

  // state commands that cancel a listening transaction
  localparam logic [4:0] CMD_FORCED_SYNTH_ON = 5'h04;
  localparam logic [4:0] CMD_FORCED_RADIO_OFF = 5'h03;

  // energy threshold step in hundredths of a dB
  localparam logic signed [16:0] THRES_STEP_CDB = 17'sd207;

  // timing, in ns, and derived counts at a 4 ns clock
  localparam int CLK_NS           = 4;
  localparam int SYMBOL_NS        = 50000;
  localparam int ASSESS_SYMBOLS   = 8;
  localparam int ASSESS_PROC_NS   = 12000;
  localparam int ASSESS_CYC       = (ASSESS_SYMBOLS * SYMBOL_NS + ASSESS_PROC_NS + CLK_NS - 1) / CLK_NS;
  localparam int LISTEN_FIXED_NS  = 5000000;
  localparam int LISTEN_MAX_NS    = 10000000;
  localparam int LISTEN_STEP_NS   = 500000;
  localparam int LISTEN_STEP_CYC  = LISTEN_STEP_NS / CLK_NS;
  localparam int LISTEN_FIXED_UNITS = LISTEN_FIXED_NS / LISTEN_STEP_NS;
  localparam int LISTEN_MAX_UNITS   = LISTEN_MAX_NS / LISTEN_STEP_NS;
  localparam int LISTEN_CHOICES     = LISTEN_MAX_UNITS - LISTEN_FIXED_UNITS + 1;

endpackage

// *** cal_listen_if.sv ***
`timescale 1ns/1ns
// start/finish handshake between the controller and the listening timer
interface cal_listen_if;
  logic start;       // one-cycle pulse, begins a listening period
  logic random_len;  // with start: 1 = random length, 0 = fixed length
  logic abort;       // one-cycle pulse, stops a running period
  logic done;        // one-cycle pulse at the end of a period
  logic running;     // level, a period is in progress
  modport timer (input start, input random_len, input abort, output done, output running);
  modport ctrl  (output start, output random_len, output abort, input done, input running);
endinterface

// *** cal_listen_timer.sv ***
`timescale 1ns/1ns
module cal_listen_timer
  import cal_pkg::*;
#(
  parameter int STEP_CYCLES = LISTEN_STEP_CYC
)
(
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  // controller side
  cal_listen_if.timer lt
);

  logic [31:0] div_cnt;    // half-millisecond divider
  logic [4:0]  units_left; // half-millisecond units still to run
  logic [7:0]  lfsr;       // pseudo-random source
  logic        run;        // period in progress

  // divider restarts on start so every period is whole units, no phase jitter
  wire         step_tick  = run && (div_cnt == 32'(STEP_CYCLES - 1));
  wire  [3:0]  rand_pick  = 4'(lfsr % 8'(LISTEN_CHOICES));
  wire  [4:0]  start_units = lt.random_len ? 5'(LISTEN_FIXED_UNITS) + 5'(rand_pick)
                                           : 5'(LISTEN_FIXED_UNITS);
  wire         last_tick  = step_tick && (units_left == 5'h01);

  assign lt.running = run;
  assign lt.done    = last_tick;

  // free-running lfsr, taps 8,6,5,4
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      lfsr <= 8'h5a;
    else
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
  end

  // period counter; abort beats start so a cancel always empties the timer
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in || lt.abort)
    begin
      run        <= 1'b0;
      div_cnt    <= 32'h0;
      units_left <= 5'h00;
    end
    else if (lt.start)
    begin
      run        <= 1'b1;
      div_cnt    <= 32'h0;
      units_left <= start_units;
    end
    else if (run)
    begin
      div_cnt <= step_tick ? 32'h0 : div_cnt + 32'h1;
      if (step_tick)
        units_left <= units_left - 5'h01;
      if (last_tick)
        run <= 1'b0;
    end
  end

endmodule

// *** test_channel_assess_listen_ctrl.sv ***
`timescale 1ns/1ns
module test_channel_assess_listen_ctrl
  import cal_pkg::*;
;
  // shortened counts keep the listening periods brief
  localparam int                 ACYC    = 20;
  localparam int                 STEP    = 4;
  localparam int                 LIMIT   = 20000;
  localparam logic [4:0]         RSTATE  = 5'h06;      // any radio state code will do
  localparam logic signed [15:0] ED_HI   = -16'sd9000; // above floor plus 4 steps
  localparam logic signed [15:0] ED_EDGE = -16'sd9172; // exactly at the threshold, so not above

  // design inputs
  logic               sys_clk_in;
  logic               rst_in;
  logic        [5:0]  reg_addr_in;
  logic        [7:0]  reg_wdata_in;
  logic               reg_wr_in;
  logic               reg_rd_in;
  logic        [4:0]  radio_state_in;
  logic               basic_rx_state_in;
  logic               extended_mode_in;
  logic               state_cmd_wr_in;
  logic        [4:0]  state_command_in;
  logic               carrier_sense_in;
  logic signed [15:0] rx_power_in;
  logic               aret_access_req_in;
  logic               aret_ack_frame_in;
  // design outputs
  logic        [7:0]  reg_rdata_out;
  logic               aret_use_listen_out;
  logic               tx_go_out;
  logic               listen_active_out;
  logic               assess_done_event_out;
  logic        [4:0]  channel_out;
  // bookkeeping
  int                 num_errors;
  int                 total_checks;
  int                 cycles;

  cal_channel_assess #(.ASSESS_CYCLES(ACYC), .STEP_CYCLES(STEP)) dut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .radio_state_in(radio_state_in), .basic_rx_state_in(basic_rx_state_in),
    .extended_mode_in(extended_mode_in), .state_cmd_wr_in(state_cmd_wr_in),
    .state_command_in(state_command_in), .carrier_sense_in(carrier_sense_in), .rx_power_in(rx_power_in),
    .aret_access_req_in(aret_access_req_in), .aret_ack_frame_in(aret_ack_frame_in),
    .aret_use_listen_out(aret_use_listen_out), .tx_go_out(tx_go_out), .listen_active_out(listen_active_out),
    .assess_done_event_out(assess_done_event_out), .channel_out(channel_out));

  // free-running clock, 4 ns period
  always #2 sys_clk_in = ~sys_clk_in;

  // hang guard: counts as a mismatch, then reports
  always @(posedge sys_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      num_errors++;
      summarize();
    end
  end

  task automatic summarize();
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // compare helpers, one per result kind
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check1(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic checkn(input string what, input int exp, input int got);
    total_checks++;
    if (got != exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // register port cycles, entered and left at a falling edge
  task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge sys_clk_in);
    reg_wr_in = 1'b0;
  endtask

  task automatic reg_read(input logic [5:0] a, output logic [7:0] d);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge sys_clk_in);
    reg_rd_in = 1'b0;
    @(negedge sys_clk_in);
    d = reg_rdata_out;
  endtask

  task automatic read_check(input string what, input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] got;
    reg_read(a, got);
    check8(what, exp, got);
  endtask

  // counts falling edges until done (sel 0) or send (sel 1) is seen, bounded
  task automatic wait_ev(input bit sel, input int lim, output int n);
    n = 0;
    while (((sel ? tx_go_out : assess_done_event_out) !== 1'b1) && (n < lim))
    begin
      @(negedge sys_clk_in);
      n++;
    end
  endtask

  task automatic aret_req(input logic ack);
    aret_ack_frame_in = ack;
    aret_access_req_in = 1'b1;
    @(negedge sys_clk_in);
    aret_access_req_in = 1'b0;
    aret_ack_frame_in = 1'b0;
  endtask

  // one manual measurement; busy worked out here from the mode table
  task automatic run_assess(input logic [1:0] m, input logic cs, input logic ed, input logic basic, input logic ext);
    int   n;
    logic busy;
    logic real_run;
    carrier_sense_in = cs;
    rx_power_in = ed ? ED_HI : ED_EDGE;
    basic_rx_state_in = basic;
    extended_mode_in = ext;
    real_run = basic & ~ext;
    busy = (m == 2'h0) ? (cs | ed) : (m == 2'h1) ? ed : (m == 2'h2) ? cs : (cs & ed);
    reg_write(ASSESS_CTRL_ADDR, {1'b1, m, 5'h03});
    wait_ev(1'b0, 100, n);
    checkn("assess_latency", real_run ? ACYC : 0, n);
    read_check("status_done", RADIO_STATUS_ADDR, {1'b1, real_run & ~busy, 1'b0, RSTATE});
  endtask

  task automatic t_reset_values();
    read_check("status_rst", RADIO_STATUS_ADDR, {3'h0, RSTATE});
    read_check("ctrl_rst", ASSESS_CTRL_ADDR, 8'h20);
    read_check("thres_rst", ENERGY_THRES_ADDR, 8'h77);
    read_check("ext_rst", EXT_OP_CTRL_ADDR, 8'h00);
    check1("use_listen_rst", 1'b0, aret_use_listen_out);
    reg_write(ENERGY_THRES_ADDR, 8'h74);
    read_check("thres_rw", ENERGY_THRES_ADDR, 8'h74);
    // unmapped index: write dropped, reads zero
    reg_write(6'h3f, 8'h5a);
    read_check("unmapped", 6'h3f, 8'h00);
    reg_write(EXT_OP_CTRL_ADDR, 8'hff);
    read_check("ext_ro_bit0", EXT_OP_CTRL_ADDR, 8'hfe);
    reg_write(EXT_OP_CTRL_ADDR, 8'h00);
    // the read also keeps the next write strobe an edge away from this one
    read_check("ext_clear", EXT_OP_CTRL_ADDR, 8'h00);
  endtask

  task automatic t_manual_clear();
    int n;
    run_assess(2'h1, 1'b0, 1'b0, 1'b1, 1'b0);
    // a new request wipes both flags until it finishes
    reg_write(ASSESS_CTRL_ADDR, 8'ha3);
    read_check("status_cleared", RADIO_STATUS_ADDR, {3'h0, RSTATE});
    read_check("trigger_self_clear", ASSESS_CTRL_ADDR, 8'h23);
    check8("channel_field", 8'h03, {3'h0, channel_out});
    wait_ev(1'b0, 100, n);
  endtask

  task automatic t_modes();
    for (int m = 0; m < 4; m++)
      for (int c = 0; c < 4; c++)
        run_assess(m[1:0], c[1], c[0], 1'b1, 1'b0);
    // outside basic receive: immediate completion, reported busy
    run_assess(2'h1, 1'b0, 1'b0, 1'b0, 1'b0);
    run_assess(2'h2, 1'b0, 1'b0, 1'b1, 1'b1);
  endtask

  task automatic t_listen_select();
    extended_mode_in = 1'b1;
    @(negedge sys_clk_in);
    check1("use_listen_bit0", 1'b0, aret_use_listen_out);
    reg_write(EXT_OP_CTRL_ADDR, 8'h40);
    extended_mode_in = 1'b0;
    @(negedge sys_clk_in);
    check1("use_listen_basic", 1'b0, aret_use_listen_out);
    extended_mode_in = 1'b1;
    @(negedge sys_clk_in);
    check1("use_listen_on", 1'b1, aret_use_listen_out);
  endtask

  // carrier-only mode ignores the strong energy, so the fixed period is clear
  task automatic t_listen_clear();
    int n;
    reg_write(ASSESS_CTRL_ADDR, 8'h40);
    carrier_sense_in = 1'b0;
    rx_power_in = ED_HI;
    aret_req(1'b0);
    // counted from the edge after the request is taken
    check1("listening", 1'b1, listen_active_out);
    wait_ev(1'b1, 200, n);
    checkn("fixed_listen", 10 * STEP, n);
    check1("listen_ended", 1'b0, listen_active_out);
  endtask

  // energy-only mode, busy for bc cycles, then the channel frees
  task automatic t_listen_busy(input int bc, input int lo, input int hi);
    int n;
    reg_write(ASSESS_CTRL_ADDR, 8'h20);
    rx_power_in = ED_HI;
    aret_req(1'b0);
    repeat (bc) @(negedge sys_clk_in);
    check1("still_listening", 1'b1, listen_active_out);
    rx_power_in = ED_EDGE;
    wait_ev(1'b1, 300, n);
    check1("relisten_window", 1'b1, (bc + n >= lo) && (bc + n <= hi));
  endtask

  task automatic t_listen_ack();
    int n;
    rx_power_in = ED_HI;
    aret_req(1'b1);
    wait_ev(1'b1, 50, n);
    checkn("ack_no_listen", 0, n);
    rx_power_in = ED_EDGE;
  endtask

  // manual trigger mid-listen does nothing, forced command aborts
  task automatic t_listen_cancel(input logic [4:0] code);
    int n;
    carrier_sense_in = 1'b0;
    aret_req(1'b0);
    reg_write(ASSESS_CTRL_ADDR, 8'hc0);
    wait_ev(1'b0, 25, n);
    checkn("no_manual_done", 25, n);
    state_command_in = code;
    state_cmd_wr_in = 1'b1;
    @(negedge sys_clk_in);
    state_cmd_wr_in = 1'b0;
    @(negedge sys_clk_in);
    check1("cancel_listen", 1'b0, listen_active_out);
    wait_ev(1'b1, 60, n);
    checkn("cancel_no_send", 60, n);
  endtask

  initial
  begin
    sys_clk_in = 1'b0;
    rst_in = 1'b1;
    reg_addr_in = 6'h00;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    radio_state_in = RSTATE;
    basic_rx_state_in = 1'b1;
    extended_mode_in = 1'b0;
    state_cmd_wr_in = 1'b0;
    state_command_in = 5'h00;
    carrier_sense_in = 1'b0;
    rx_power_in = ED_EDGE;
    aret_access_req_in = 1'b0;
    aret_ack_frame_in = 1'b0;
    num_errors = 0;
    total_checks = 0;
    cycles = 0;
    repeat (20) @(negedge sys_clk_in);
    rst_in = 1'b0;
    t_reset_values();
    t_manual_clear();
    t_modes();
    t_listen_select();
    t_listen_clear();
    t_listen_busy(30, 20 * STEP, 30 * STEP);
    t_listen_busy(130, 170, 292);
    t_listen_ack();
    t_listen_cancel(CMD_FORCED_SYNTH_ON);
    t_listen_cancel(CMD_FORCED_RADIO_OFF);
    summarize();
  end
endmodule
